// ### hdl/ffl_flag_top.sv
// status flag logic of a fifo with programmable almost-empty and almost-full
`include "ffl_defs.svh"

module ffl_flag_top #(
    parameter int DEPTH = `FFL_DEPTH,  // fifo depth in words
    parameter int DW    = `FFL_DATA_W, // output bus width
    parameter int OW    = $clog2(DEPTH) // offset width
) (
    input  wire logic          sys_clk_in,              // 25 mhz system clock
    input  wire logic          rst_n_in,                // async reset, active low
    input  wire logic          ce_in,                   // clock enable, freezes state
    input  wire logic          master_reset_n_in,       // master reset pin, active low
    input  wire logic          offset_load_select_in,   // load select pin
    input  wire logic          load_method_pin_in,      // default table column
    input  wire logic          default_offset_pick_0_in, // default pick bit 0
    input  wire logic          default_offset_pick_1_in, // default pick bit 1
    input  wire logic          flag_timing_select_in,   // almost flag timing pin
    input  wire logic          wr_tick_in,              // write clock rising edge
    input  wire logic          rd_tick_in,              // read clock rising edge
    input  wire logic          wr_en_in,                // write request
    input  wire logic          rd_en_in,                // read request
    input  wire logic          ofs_wr_in,               // parallel offset write
    input  wire logic          ofs_sel_in,              // 0 empty, 1 full offset
    input  wire logic [OW-1:0] ofs_data_in,             // parallel offset value
    input  wire logic          ser_shift_in,            // serial offset shift
    input  wire logic          ser_bit_in,              // serial offset bit
    input  wire logic          ofs_rd_in,               // offset readback request
    output logic               empty_flag_n_out,        // empty, active low
    output logic               almost_empty_flag_n_out, // almost empty, active low
    output logic               half_full_flag_n_out,    // half full, active low
    output logic               almost_full_flag_n_out,  // almost full, active low
    output logic               full_flag_n_out,         // full, active low
    output logic               wr_accept_out,           // write taken, pulse
    output logic               rd_accept_out,           // read taken, pulse
    output logic [DW-1:0]      data_out_bus_out,        // offset readback data
    output logic               ofs_valid_out,           // readback data valid, pulse
    output logic               serial_mode_out          // serial loading selected
);

    localparam int CW = OW + 1;                     // occupancy width
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH); // full count
    localparam logic [CW-1:0] HALF_C  = CW'(DEPTH / 2); // half count

    ffl_ofs_if #(.OW(OW)) ofs ();     // link to the offset store

    ffl_pkg::ffl_method_t method_ff; // latched loading method
    ffl_pkg::ffl_timing_t timing_ff; // latched almost flag timing

    logic [CW-1:0] wptr_ff;          // write pointer
    logic [CW-1:0] rptr_ff;          // read pointer
    logic [CW-1:0] rptr_w1_ff;       // read pointer, first stage on write side
    logic [CW-1:0] rptr_w2_ff;       // read pointer, seen by write side
    logic [CW-1:0] wptr_r1_ff;       // write pointer, first stage on read side
    logic [CW-1:0] wptr_r2_ff;       // write pointer, seen by read side
    logic          empty_n_ff;       // empty flag
    logic          pae_n_ff;         // almost empty flag
    logic          hf_n_ff;          // half full flag
    logic          paf_n_ff;         // almost full flag
    logic          full_n_ff;        // full flag
    logic          wr_acc_ff;        // write accepted
    logic          rd_acc_ff;        // read accepted
    logic [DW-1:0] dout_ff;          // readback data
    logic          dval_ff;          // readback valid

    logic          master_reset;              // master reset active
    logic [CW-1:0] wcnt;             // occupancy seen by the write side
    logic [CW-1:0] rcnt;             // occupancy seen by the read side
    logic          wr_take;          // write taken this cycle
    logic          rd_take;          // read taken this cycle
    logic [CW-1:0] wview;            // write side count after this write
    logic [CW-1:0] rview;            // read side count after this read
    logic          is_sync;          // synchronous almost flag timing

    // occupancy at or above the almost-full threshold
    function automatic logic paf_hit(input logic [CW-1:0] cnt, input logic [OW-1:0] m);
        return cnt >= (DEPTH_C - {1'b0, m});
    endfunction : paf_hit

    // occupancy at or below the almost-empty threshold
    function automatic logic pae_hit(input logic [CW-1:0] cnt, input logic [OW-1:0] n);
        return cnt <= {1'b0, n};
    endfunction : pae_hit

    // occupancy above half the depth
    function automatic logic hf_hit(input logic [CW-1:0] cnt);
        return cnt > HALF_C;
    endfunction : hf_hit

    assign master_reset     = !master_reset_n_in;
    assign is_sync = (timing_ff == ffl_pkg::FFL_SYNC);
    assign wcnt    = wptr_ff - rptr_w2_ff;
    assign rcnt    = wptr_r2_ff - rptr_ff;
    // data moves only with load select high; a full count blocks the write
    assign wr_take = wr_tick_in && wr_en_in && offset_load_select_in
                     && (wcnt != DEPTH_C);
    assign rd_take = rd_tick_in && rd_en_in && offset_load_select_in && (rcnt != '0);
    assign wview   = wcnt + {{(CW-1){1'b0}}, wr_take};
    assign rview   = rcnt - {{(CW-1){1'b0}}, rd_take};

    // offset store hookup
    assign ofs.ce           = ce_in;
    assign ofs.load_default = master_reset;
    assign ofs.pick         = {load_method_pin_in, default_offset_pick_1_in,
                               default_offset_pick_0_in};
    assign ofs.ser_mode     = (method_ff == ffl_pkg::FFL_SERIAL);
    assign ofs.par_wr       = ofs_wr_in && !master_reset;
    assign ofs.par_sel      = ofs_sel_in;
    assign ofs.par_data     = ofs_data_in;
    assign ofs.ser_shift    = ser_shift_in && !master_reset;
    assign ofs.ser_bit      = ser_bit_in;

    ffl_offset_regs #(.OW(OW)) u_ofs (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .ofs        (ofs.store)
    );

    // configuration pins are caught while master reset is held
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            method_ff <= ffl_pkg::FFL_PARALLEL;
            timing_ff <= ffl_pkg::FFL_ASYNC;
        end else if (ce_in && master_reset) begin
            method_ff <= offset_load_select_in ? ffl_pkg::FFL_SERIAL
                                               : ffl_pkg::FFL_PARALLEL;
            timing_ff <= flag_timing_select_in ? ffl_pkg::FFL_SYNC
                                               : ffl_pkg::FFL_ASYNC;
        end
    end

    // write side: pointer and read pointer copy, moved on write edges
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wptr_ff    <= '0;
            rptr_w1_ff <= '0;
            rptr_w2_ff <= '0;
        end else if (ce_in) begin
            if (master_reset) begin
                wptr_ff    <= '0;
                rptr_w1_ff <= '0;
                rptr_w2_ff <= '0;
            end else if (wr_tick_in) begin
                wptr_ff    <= wptr_ff + {{(CW-1){1'b0}}, wr_take};
                rptr_w1_ff <= rptr_ff;
                rptr_w2_ff <= rptr_w1_ff;
            end
        end
    end

    // read side: pointer and write pointer copy, moved on read edges
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rptr_ff    <= '0;
            wptr_r1_ff <= '0;
            wptr_r2_ff <= '0;
        end else if (ce_in) begin
            if (master_reset) begin
                rptr_ff    <= '0;
                wptr_r1_ff <= '0;
                wptr_r2_ff <= '0;
            end else if (rd_tick_in) begin
                rptr_ff    <= rptr_ff + {{(CW-1){1'b0}}, rd_take};
                wptr_r1_ff <= wptr_ff;
                wptr_r2_ff <= wptr_r1_ff;
            end
        end
    end

    // full on write edges, empty on read edges, half full on either
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            full_n_ff  <= `FFL_FLAG_OFF;
            empty_n_ff <= `FFL_FLAG_ON;
            hf_n_ff    <= `FFL_FLAG_OFF;
        end else if (ce_in) begin
            if (master_reset) begin
                full_n_ff  <= `FFL_FLAG_OFF;
                empty_n_ff <= `FFL_FLAG_ON;
                hf_n_ff    <= `FFL_FLAG_OFF;
            end else begin
                if (wr_tick_in) begin
                    full_n_ff <= (wview != DEPTH_C);
                end
                if (rd_tick_in) begin
                    empty_n_ff <= (rview != '0);
                    hf_n_ff    <= !hf_hit(rview);
                end else if (wr_tick_in) begin
                    hf_n_ff    <= !hf_hit(wview);
                end
            end
        end
    end

    // almost full: write edges only when sync, set/clear split when async
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            paf_n_ff <= `FFL_FLAG_OFF;
        end else if (ce_in) begin
            if (master_reset) begin
                paf_n_ff <= `FFL_FLAG_OFF;
            end else if (is_sync) begin
                if (wr_tick_in) begin
                    paf_n_ff <= !paf_hit(wview, ofs.full_ofs);
                end
            end else if (wr_tick_in && paf_hit(wview, ofs.full_ofs)) begin
                paf_n_ff <= `FFL_FLAG_ON;
            end else if (rd_tick_in && !paf_hit(rview, ofs.full_ofs)) begin
                paf_n_ff <= `FFL_FLAG_OFF;
            end
        end
    end

    // almost empty: read edges only when sync, set/clear split when async
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pae_n_ff <= `FFL_FLAG_ON;
        end else if (ce_in) begin
            if (master_reset) begin
                pae_n_ff <= `FFL_FLAG_ON;
            end else if (is_sync) begin
                if (rd_tick_in) begin
                    pae_n_ff <= !pae_hit(rview, ofs.empty_ofs);
                end
            end else if (rd_tick_in && pae_hit(rview, ofs.empty_ofs)) begin
                pae_n_ff <= `FFL_FLAG_ON;
            end else if (wr_tick_in && !pae_hit(wview, ofs.empty_ofs)) begin
                pae_n_ff <= `FFL_FLAG_OFF;
            end
        end
    end

    // accept pulses for data transfers
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_acc_ff <= 1'h0;
            rd_acc_ff <= 1'h0;
        end else if (ce_in) begin
            wr_acc_ff <= wr_take && !master_reset;
            rd_acc_ff <= rd_take && !master_reset;
        end
    end

    // offsets are read back only over the parallel bus, in either method
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dout_ff <= '0;
            dval_ff <= 1'h0;
        end else if (ce_in) begin
            dval_ff <= ofs_rd_in && !master_reset;
            if (ofs_rd_in && !master_reset) begin
                dout_ff <= DW'(ofs_sel_in ? ofs.full_ofs : ofs.empty_ofs);
            end
        end
    end

    assign empty_flag_n_out        = empty_n_ff;
    assign almost_empty_flag_n_out = pae_n_ff;
    assign half_full_flag_n_out    = hf_n_ff;
    assign almost_full_flag_n_out  = paf_n_ff;
    assign full_flag_n_out         = full_n_ff;
    assign wr_accept_out           = wr_acc_ff;
    assign rd_accept_out           = rd_acc_ff;
    assign data_out_bus_out        = dout_ff;
    assign ofs_valid_out           = dval_ff;
    assign serial_mode_out         = method_ff[1]; // serial code is the only one with bit 1 set

    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_mrs_cfg;
        ce_in && master_reset && flag_timing_select_in;
    endsequence
    sequence s_run_sync;
        (ce_in && !master_reset) [*2];
    endsequence

    a_timing_latch_sync: assert property (
        s_mrs_cfg ##1 s_run_sync |-> is_sync)
        else $error("sync timing not latched at master reset");
    a_method_latch: assert property (
        (ce_in && master_reset) |=> (serial_mode_out == $past(offset_load_select_in)))
        else $error("loading method does not follow load select");
    a_default_load: assert property (
        (ce_in && master_reset && ofs.pick == `FFL_PICK_1023)
        |=> (ofs.empty_ofs == OW'(`FFL_OFS_1023)) && (ofs.full_ofs == OW'(`FFL_OFS_1023)))
        else $error("default offset not loaded");
    a_full_blocks_wr: assert property (
        (wcnt == DEPTH_C) |=> !wr_accept_out)
        else $error("write taken while full");
    a_paf_sync_hold: assert property (
        (ce_in && !master_reset && is_sync && !wr_tick_in) |=> $stable(almost_full_flag_n_out))
        else $error("sync almost full moved without write edge");
    a_pae_sync_hold: assert property (
        (ce_in && !master_reset && is_sync && !rd_tick_in) |=> $stable(almost_empty_flag_n_out))
        else $error("sync almost empty moved without read edge");
    a_paf_async_edges: assert property (
        (!is_sync && !$past(master_reset) && $rose(almost_full_flag_n_out)) |-> $past(rd_tick_in))
        else $error("async almost full released off a read edge");
    a_pae_async_edges: assert property (
        (!is_sync && !$past(master_reset) && $rose(almost_empty_flag_n_out)) |-> $past(wr_tick_in))
        else $error("async almost empty released off a write edge");
    a_empty_at_zero: assert property (
        (ce_in && !master_reset && rd_tick_in && rview == '0) |=> !empty_flag_n_out)
        else $error("empty flag not low at zero words");
    a_readback_data: assert property (
        (ce_in && !master_reset && ofs_rd_in && !ofs_sel_in)
        |=> ofs_valid_out && (data_out_bus_out == DW'($past(ofs.empty_ofs))))
        else $error("readback does not show empty offset");

endmodule : ffl_flag_top

// ### hdl/ffl_defs.svh
// constants for the fifo programmable flag logic
`ifndef FFL_DEFS_SVH
`define FFL_DEFS_SVH

`define FFL_DEPTH        32'h0000_4000 // smallest documented depth, words
`define FFL_DATA_W       32'h0000_0048 // width of the parallel output bus

// default offset codes, {load_method_pin, pick_1, pick_0}
`define FFL_PICK_1023    3'h4
`define FFL_PICK_511     3'h2
`define FFL_PICK_255     3'h1
`define FFL_PICK_127     3'h0
`define FFL_PICK_63      3'h3
`define FFL_PICK_31      3'h6
`define FFL_PICK_15      3'h5
`define FFL_PICK_7       3'h7

// default offset values
`define FFL_OFS_1023     32'h0000_03ff
`define FFL_OFS_511      32'h0000_01ff
`define FFL_OFS_255      32'h0000_00ff
`define FFL_OFS_127      32'h0000_007f
`define FFL_OFS_63       32'h0000_003f
`define FFL_OFS_31       32'h0000_001f
`define FFL_OFS_15       32'h0000_000f
`define FFL_OFS_7        32'h0000_0007

// levels of the active-low flags
`define FFL_FLAG_ON      1'h0
`define FFL_FLAG_OFF     1'h1

`endif

// ### hdl/ffl_pkg.sv
// types shared by the fifo programmable flag logic
package ffl_pkg;

    // offset loading method, latched at master reset
    typedef enum logic [1:0] {
        FFL_PARALLEL = 2'h1,
        FFL_SERIAL   = 2'h2
    } ffl_method_t;

    // timing of the almost flags, latched at master reset
    typedef enum logic [1:0] {
        FFL_ASYNC = 2'h1,
        FFL_SYNC  = 2'h2
    } ffl_timing_t;

endpackage : ffl_pkg

// ### hdl/ffl_ofs_if.sv
// interface between the flag logic and its offset store
interface ffl_ofs_if #(
    parameter int OW = 14 // offset width
);
    logic          ce;           // clock enable
    logic          load_default; // master reset: load a default offset
    logic [2:0]    pick;         // default offset code
    logic          ser_mode;     // serial loading selected
    logic          par_wr;       // parallel write strobe
    logic          par_sel;      // 0 empty offset, 1 full offset
    logic [OW-1:0] par_data;     // parallel write value
    logic          ser_shift;    // serial shift strobe
    logic          ser_bit;      // serial data bit
    logic [OW-1:0] empty_ofs;    // stored empty offset n
    logic [OW-1:0] full_ofs;     // stored full offset m

    modport ctl (
        output ce, load_default, pick, ser_mode, par_wr, par_sel, par_data,
        output ser_shift, ser_bit,
        input  empty_ofs, full_ofs
    );
    modport store (
        input  ce, load_default, pick, ser_mode, par_wr, par_sel, par_data,
        input  ser_shift, ser_bit,
        output empty_ofs, full_ofs
    );
endinterface : ffl_ofs_if

// ### hdl/ffl_offset_regs.sv
// empty and full offset registers with default, serial and parallel loading
`include "ffl_defs.svh"

module ffl_offset_regs #(
    parameter int OW = 14 // offset width
) (
    input wire logic sys_clk_in, // system clock
    input wire logic rst_n_in,   // asynchronous reset, active low
    ffl_ofs_if.store ofs         // offset control from the flag logic
);

    logic [OW-1:0] empty_ofs_ff; // empty offset n
    logic [OW-1:0] full_ofs_ff;  // full offset m

    // decode a default offset code into its value
    function automatic logic [OW-1:0] dflt_ofs(input logic [2:0] code);
        logic [31:0] v;
        v = `FFL_OFS_127;
        case (code)
            `FFL_PICK_1023: v = `FFL_OFS_1023;
            `FFL_PICK_511:  v = `FFL_OFS_511;
            `FFL_PICK_255:  v = `FFL_OFS_255;
            `FFL_PICK_127:  v = `FFL_OFS_127;
            `FFL_PICK_63:   v = `FFL_OFS_63;
            `FFL_PICK_31:   v = `FFL_OFS_31;
            `FFL_PICK_15:   v = `FFL_OFS_15;
            `FFL_PICK_7:    v = `FFL_OFS_7;
            default:        v = `FFL_OFS_127;
        endcase
        return v[OW-1:0];
    endfunction : dflt_ofs

    // both offsets take the default at master reset, then load by the method
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            empty_ofs_ff <= OW'(`FFL_OFS_127);
            full_ofs_ff  <= OW'(`FFL_OFS_127);
        end else if (ofs.ce) begin
            if (ofs.load_default) begin
                empty_ofs_ff <= dflt_ofs(ofs.pick);
                full_ofs_ff  <= dflt_ofs(ofs.pick);
            end else if (ofs.ser_mode && ofs.ser_shift) begin
                // bits enter the full offset and carry on into the empty one
                {empty_ofs_ff, full_ofs_ff} <= {empty_ofs_ff[OW-2:0], full_ofs_ff, ofs.ser_bit};
            end else if (!ofs.ser_mode && ofs.par_wr) begin
                if (ofs.par_sel) begin
                    full_ofs_ff <= ofs.par_data;
                end else begin
                    empty_ofs_ff <= ofs.par_data;
                end
            end
        end
    end

    assign ofs.empty_ofs = empty_ofs_ff;
    assign ofs.full_ofs  = full_ofs_ff;

endmodule : ffl_offset_regs

// ### test/ffl_partner.sv
// far-side model: system logic clocking words into and out of the fifo
module ffl_partner (
    input  wire logic       wr_go_in,    // write one word this cycle
    input  wire logic       rd_go_in,    // read one word this cycle
    input  wire logic [1:0] idle_in,     // bare edges: 0 write clock, 1 read clock
    input  wire logic       mrs_in,      // master reset in progress
    input  wire logic       ld_cfg_in,   // load select wanted at master reset
    output logic            wr_tick_out, // write clock edge
    output logic            rd_tick_out, // read clock edge
    output logic            wr_en_out,   // write enable
    output logic            rd_en_out,   // read enable
    output logic            ld_out       // load select pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // an edge comes with every transfer and every bare edge request
    assign wr_tick_out = wr_go_in | idle_in[0];
    assign rd_tick_out = rd_go_in | idle_in[1];
    assign wr_en_out   = wr_go_in;
    assign rd_en_out   = rd_go_in;
    // held high after master reset so that transfers are taken
    assign ld_out = mrs_in ? ld_cfg_in : 1'h1;
endmodule : ffl_partner

// ### test/testbench.sv
// self-checking bench for the fifo flag logic
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int D = 16; // shrunk depth
    logic clk, rst_n, mrs_n, ldc, tdp, p1, p0, ts, wg, rg, wt, rt, we, re, ld, ow, os, sh, sb, orq;
    logic ef, ae, hf, af, ff, wa, ra, ov, sm;
    logic [1:0] idl;    // bare clock edges
    logic [13:0] od;    // offset value
    logic [71:0] q;     // readback bus
    int n_mismatch, n_checks, cnt, n, m;
    int dflt[8] = '{127, 255, 511, 63, 1023, 15, 31, 7}; // default per pin code
    ffl_partner i_ffl_partner (.wr_go_in(wg), .rd_go_in(rg), .idle_in(idl), .mrs_in(!mrs_n),
        .ld_cfg_in(ldc), .wr_tick_out(wt), .rd_tick_out(rt), .wr_en_out(we), .rd_en_out(re),
        .ld_out(ld));
    ffl_flag_top #(.DEPTH(D), .OW(14)) i_ffl_flag_top (.sys_clk_in(clk), .rst_n_in(rst_n),
        .ce_in(1'h1), .master_reset_n_in(mrs_n), .offset_load_select_in(ld),
        .load_method_pin_in(tdp), .default_offset_pick_0_in(p0), .default_offset_pick_1_in(p1),
        .flag_timing_select_in(ts), .wr_tick_in(wt), .rd_tick_in(rt), .wr_en_in(we),
        .rd_en_in(re), .ofs_wr_in(ow), .ofs_sel_in(os), .ofs_data_in(od), .ser_shift_in(sh),
        .ser_bit_in(sb), .ofs_rd_in(orq), .empty_flag_n_out(ef), .almost_empty_flag_n_out(ae),
        .half_full_flag_n_out(hf), .almost_full_flag_n_out(af), .full_flag_n_out(ff),
        .wr_accept_out(wa), .rd_accept_out(ra), .data_out_bus_out(q), .ofs_valid_out(ov),
        .serial_mode_out(sm));
    // compare and count
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    // master reset with pin code, load select and timing select
    task automatic mreset(input logic [2:0] c, input logic l, input logic t);
        @(negedge clk);
        {tdp, p1, p0} = c;
        ldc = l;
        ts = t;
        mrs_n = 1'h0;
        repeat (2) @(negedge clk);
        mrs_n = 1'h1;
        chk(sm, l);
    endtask : mreset
    // offset readback over the parallel bus
    task automatic rdback(input logic sel, input int exp);
        @(negedge clk);
        orq = 1'h1;
        os = sel;
        @(negedge clk);
        orq = 1'h0;
        chk(ov, 1'h1);
        chk(q, 72'(exp));
    endtask : rdback
    // parallel offset write
    task automatic pwr(input logic sel, input logic [13:0] v);
        @(negedge clk);
        ow = 1'h1;
        os = sel;
        od = v;
        @(negedge clk);
        ow = 1'h0;
    endtask : pwr
    // bare edges on the chosen clocks for k cycles
    task automatic ticks(input logic [1:0] s, input int k);
        idl = s;
        repeat (k) @(negedge clk);
        idl = 2'h0;
    endtask : ticks
    // one transfer with expected accept pulses
    task automatic xfer(input logic w, input logic r, input logic ew, input logic er);
        @(negedge clk);
        wg = w;
        rg = r;
        @(negedge clk);
        wg = 1'h0;
        rg = 1'h0;
        chk(wa, ew);
        chk(ra, er);
    endtask : xfer
    // settle both sides, then all five flags against the occupancy
    task automatic flags();
        ticks(2'h3, 4);
        chk(ef, cnt != 0);
        chk(ae, !(cnt <= n));
        chk(hf, !(cnt > D / 2));
        chk(af, !(cnt >= D - m));
        chk(ff, cnt != D);
    endtask : flags
    // closing verdict
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    // 25 mhz clock
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // watchdog, far beyond the expected run
    initial begin
        #400000;
        n_mismatch++;
        final_report();
    end
    // main sequence
    initial begin
        {rst_n, ldc, tdp, p1, p0, ts, wg, rg, ow, os, sh, sb, orq, od, idl} = '0;
        mrs_n = 1'h1;
        repeat (16) @(negedge clk);
        rst_n = 1'h1;
        for (int c = 0; c < 8; c++) begin
            mreset(3'(c), c[0], 1'h1);
            rdback(1'h0, dflt[c]);
            rdback(1'h1, dflt[c]);
        end
        mreset(3'h7, 1'h0, 1'h1);
        pwr(1'h0, 14'h0005);
        pwr(1'h1, 14'h000f);
        rdback(1'h0, 5);
        rdback(1'h1, 15);
        mreset(3'h7, 1'h1, 1'h1);
        for (int b = 27; b >= 0; b--) begin
            @(negedge clk);
            sh = 1'h1;
            sb = 28'({14'h0009, 14'h000c}) >> b & 1;
        end
        @(negedge clk);
        sh = 1'h0;
        pwr(1'h0, 14'h0001);
        rdback(1'h0, 9);
        rdback(1'h1, 12);
        for (int t = 0; t < 2; t++) begin
            mreset(3'h7, 1'h0, t[0]);
            n = 7;
            m = 7;
            cnt = 0;
            flags();
            for (int i = 0; i < D; i++) begin
                xfer(1'h1, 1'h0, 1'h1, 1'h0);
                cnt++;
                if (cnt == 8) begin
                    ticks(2'h1, 2);
                    chk(ae, !t[0]);
                end
                flags();
            end
            xfer(1'h1, 1'h0, 1'h0, 1'h0);
            for (int i = 0; i < D; i++) begin
                xfer(1'h0, 1'h1, 1'h0, 1'h1);
                cnt--;
                if (cnt == 8) begin
                    ticks(2'h2, 2);
                    chk(af, !t[0]);
                end
                flags();
            end
            xfer(1'h0, 1'h1, 1'h0, 1'h0);
        end
        final_report();
    end
endmodule : testbench
